//--- mmm_mdc_gen.sv
// Management clock divider: half period of N bus clocks, stopped low at N = 0.
// Assumes one bus clock domain and a clock enable that freezes it.
`timescale 1ns/1ps
`include "mmm_regs.svh"

module mmm_mdc_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [5:0] div_i,
  output logic mdc_o,
  output mmm_pkg::mmm_mdc_evt_t evt_o
);

  logic [5:0] div_reg;
  logic [5:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= `MMM_DIV_ZERO;
      cnt_reg <= `MMM_DIV_ZERO;
      mdc_o <= 1'b0;
      evt_o <= '0;
    end else if (ce_i) begin
      evt_o <= '0;
      if (div_reg == `MMM_DIV_ZERO) begin
        // Stopped and low; pick up a new divider at once
        mdc_o <= 1'b0; // R14
        cnt_reg <= `MMM_DIV_ZERO;
        div_reg <= div_i;
      end else if (cnt_reg == div_reg - `MMM_DIV_ONE) begin
        // New divider only at an edge keeps each half period whole
        cnt_reg <= `MMM_DIV_ZERO;
        div_reg <= div_i; // R19
        mdc_o <= ~mdc_o & (div_i != `MMM_DIV_ZERO); // R15
        evt_o.rise <= ~mdc_o & (div_i != `MMM_DIV_ZERO);
        evt_o.fall <= mdc_o;
      end else begin
        cnt_reg <= cnt_reg + `MMM_DIV_ONE;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  stop_low_a: assert property (div_reg == `MMM_DIV_ZERO |-> !mdc_o) // R14
    else $error("management clock not low while stopped");
  half_period_a: assert property (evt_o.rise |-> $past(cnt_reg) == $past(div_reg) - `MMM_DIV_ONE) // R15
    else $error("management clock half period wrong");
  edge_pulse_a: assert property (evt_o.rise |-> mdc_o && !evt_o.fall) // R19
    else $error("rise event without high clock");

endmodule

//--- mmm_phy_model.sv
// Behavioural PHY on the management pins: records frames and answers reads.
// Assumes at least two bus clocks per mdc half period; data line pulled up.
`timescale 1ns/1ps
module mmm_phy_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mdc_i,
  input wire logic dat_i,
  input wire logic oe_i,
  input wire logic [15:0] rdata_i,
  output logic line_o,
  output logic [31:0] sr_o,
  output logic [6:0] len_o
);
  logic mdc_d;
  logic oe_d;
  logic [6:0] cnt;
  logic [4:0] ph;
  // The master moves its enable in the same bus cycle as this model sees mdc fall,
  // so the enable is remembered from fall to fall to catch a release
  always_ff @(posedge clk_i) begin
    mdc_d <= mdc_i;
    if (rst_i) begin
      oe_d <= 1'b0;
      cnt <= 7'h00;
      ph <= 5'h00;
      line_o <= 1'b1;
      sr_o <= 32'h0;
      len_o <= 7'h00;
    end else if (!mdc_d && mdc_i && oe_i) begin
      sr_o <= {sr_o[30:0], dat_i};
      cnt <= cnt + 7'h01;
    end else if (mdc_d && !mdc_i) begin
      oe_d <= oe_i;
      if (!oe_i)
        cnt <= 7'h00;
      if (oe_d && !oe_i)
        len_o <= cnt;
      // Release after fifteen header bits marks a read; data starts at this fall
      if (oe_d && !oe_i && cnt[4:0] == 5'h0f) begin
        ph <= 5'h01;
        line_o <= rdata_i[15];
      end else if (ph == 5'h10) begin
        ph <= 5'h00;
        line_o <= 1'b1;
      end else if (ph != 5'h00) begin
        line_o <= rdata_i[4'(5'h0f - ph)];
        ph <= ph + 5'h01;
      end
    end
  end
endmodule

//--- mmm_pkg.sv
// Types shared by the management master and its clock generator.
// Constants live in mmm_regs.svh.
package mmm_pkg;

  typedef enum logic [2:0] {
    MMM_IDLE,
    MMM_ARM,
    MMM_PRE,
    MMM_SHIFT,
    MMM_END
  } mmm_state_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } mmm_mdc_evt_t;

endpackage

//--- mmm_regs.svh
// Register offsets, field positions, reset values and counts of the management master.
// Included by bare name from the design files; definitions only.
`ifndef MMM_REGS_SVH
`define MMM_REGS_SVH

`define MMM_EVENT_OFS 16'h3004
`define MMM_ENABLE_OFS 16'h3008
`define MMM_FRAME_OFS 16'h3040
`define MMM_DIVCTL_OFS 16'h3044
`define MMM_STATUS_OFS 16'h3048
`define MMM_ADR_HI 13
`define MMM_ADR_LO 2
`define MMM_MIN_ADR_W 14

`define MMM_FRAME_MSB 31
`define MMM_OP_MSB 29
`define MMM_HDR_HI 31
`define MMM_HDR_LO 16
`define MMM_DATA_HI 15
`define MMM_DATA_LO 0

`define MMM_SKIP_BIT 7
`define MMM_DIV_HI 6
`define MMM_DIV_LO 1
`define MMM_DIVCTL_MASK 8'hfe
`define MMM_DIVCTL_RST 8'h00
`define MMM_DIV_ZERO 6'h00
`define MMM_DIV_ONE 6'h01

`define MMM_DONE_BIT 23
`define MMM_DONE_LANE 2
`define MMM_BUSY_BIT 0
`define MMM_PEND_BIT 1

`define MMM_BIT_ZERO 5'h00
`define MMM_BIT_ONE 5'h01
`define MMM_BIT_LAST 5'h1f
`define MMM_TA2_IDX 5'h0f
`define MMM_DATA_IDX 5'h10

`endif

//--- mmm_top.sv
// Management frame master with classic Wishbone register slave.
// Assumes synchronous inputs, one clock, and a PHY answering on the data line.
//
// Summary of operation
// R01: Software loads start field with 01.
// R02: Software sets operation 10 read, 01 write.
// R03: Operation upper bit picks read or write.
// R04: PHY select taken from bits 4 to 8.
// R05: PHY register select from bits 9 to 13.
// R06: Software sets turnaround field to 10.
// R07: Data field carries write or read data.
// R08: Frame write starts preamble then shifting.
// R09: Frame register rotates while shifting.
// R10: Write frame ends restored, event raised.
// R11: Read frame ends with PHY data, event.
// R12: Software avoids writes during a frame.
// R13: Preamble skip drops the 32 ones.
// R14: Divider zero stops clock low.
// R15: Clock is bus clock over 2N.
// R16: Software keeps management clock under 2.5 MHz.
// R17: No frame while divider is zero.
// R18: Software may zero divider after frames.
// R19: Even duty, divider change at edges.
// R20: Pending frame launches on nonzero divider.
// R21: Interrupt when flag and enable; W1C.
// R22: Frame register has no reset value.
// R23: MSB first, read releases at second turnaround.
`timescale 1ns/1ps
`include "mmm_regs.svh"

module mmm_top #(
  parameter int ADDR_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mdc_o,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  output logic irq_o
);

  generate
    if (ADDR_W < `MMM_MIN_ADR_W) begin : g_bad_adr
      $error("ADDR_W too small for the register map");
    end
  endgenerate

  function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [15:0] ofs);
    hit = adr[`MMM_ADR_HI:`MMM_ADR_LO] == ofs[`MMM_ADR_HI:`MMM_ADR_LO];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  mmm_pkg::mmm_state_t state_reg;
  mmm_pkg::mmm_mdc_evt_t mdc_evt;
  logic [31:0] frame_reg;
  logic [7:0] divctl_reg;
  logic [4:0] bit_reg;
  logic rd_reg;
  logic pend_reg;
  logic done_reg;
  logic flag_reg;
  logic enable_reg;
  logic req;
  logic wr_take;
  logic launch;
  logic [5:0] div_field;
  logic rx_phase;
  logic [31:0] rd_mux;

  assign req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_take = req & wb_we_i & wb_ack_o;
  assign div_field = divctl_reg[`MMM_DIV_HI:`MMM_DIV_LO];
  assign launch = (state_reg == mmm_pkg::MMM_IDLE) & pend_reg & (div_field != `MMM_DIV_ZERO);
  assign rx_phase = rd_reg & (bit_reg >= `MMM_DATA_IDX);

  mmm_mdc_gen u_mdc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .div_i(div_field),
    .mdc_o(mdc_o),
    .evt_o(mdc_evt)
  );

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit(wb_adr_i, `MMM_FRAME_OFS)) begin
      rd_mux = frame_reg;
    end else if (hit(wb_adr_i, `MMM_DIVCTL_OFS)) begin
      rd_mux[7:0] = divctl_reg;
    end else if (hit(wb_adr_i, `MMM_EVENT_OFS)) begin
      rd_mux[`MMM_DONE_BIT] = flag_reg;
    end else if (hit(wb_adr_i, `MMM_ENABLE_OFS)) begin
      rd_mux[`MMM_DONE_BIT] = enable_reg;
    end else if (hit(wb_adr_i, `MMM_STATUS_OFS)) begin
      rd_mux[`MMM_BUSY_BIT] = state_reg != mmm_pkg::MMM_IDLE;
      rd_mux[`MMM_PEND_BIT] = pend_reg;
    end
  end

  // Bus answer: ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divctl_reg <= `MMM_DIVCTL_RST;
    end else if (ce_i && wr_take && hit(wb_adr_i, `MMM_DIVCTL_OFS) && wb_sel_i[0]) begin
      divctl_reg <= wb_dat_i[7:0] & `MMM_DIVCTL_MASK;
    end
  end

  // No reset here: software must program the frame first
  always_ff @(posedge clk_i) begin // R22
    if (ce_i) begin
      if (wr_take && hit(wb_adr_i, `MMM_FRAME_OFS)) begin
        frame_reg <= merge(frame_reg, wb_dat_i, wb_sel_i); // R04 R05
      end else if (state_reg == mmm_pkg::MMM_SHIFT && mdc_evt.rise) begin
        // Rotation restores the header; read data replaces the low half
        frame_reg <= {frame_reg[30:0], rx_phase ? mdio_i : frame_reg[`MMM_FRAME_MSB]}; // R09 R07 R10 R11
      end
    end
  end

  // A write while stopped waits here for a nonzero divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_take && hit(wb_adr_i, `MMM_FRAME_OFS)) begin
        pend_reg <= 1'b1; // R08 R20
      end else if (launch) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Frame engine: drive on the falling edge, sample on the rising one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= mmm_pkg::MMM_IDLE;
      bit_reg <= `MMM_BIT_ZERO;
      rd_reg <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce_i) begin
      done_reg <= 1'b0;
      unique case (state_reg)
        mmm_pkg::MMM_IDLE: begin
          if (launch) begin // R17 R20
            state_reg <= mmm_pkg::MMM_ARM;
            rd_reg <= frame_reg[`MMM_OP_MSB]; // R03
            bit_reg <= `MMM_BIT_ZERO;
          end
        end
        mmm_pkg::MMM_ARM: begin
          if (mdc_evt.fall) begin
            mdio_oe_o <= 1'b1;
            if (divctl_reg[`MMM_SKIP_BIT]) begin
              state_reg <= mmm_pkg::MMM_SHIFT; // R13
              mdio_o <= frame_reg[`MMM_FRAME_MSB];
            end else begin
              state_reg <= mmm_pkg::MMM_PRE; // R08
              mdio_o <= 1'b1;
            end
          end
        end
        mmm_pkg::MMM_PRE: begin
          if (mdc_evt.rise) begin
            if (bit_reg == `MMM_BIT_LAST) begin
              state_reg <= mmm_pkg::MMM_SHIFT; // R13
              bit_reg <= `MMM_BIT_ZERO;
            end else begin
              bit_reg <= bit_reg + `MMM_BIT_ONE;
            end
          end
        end
        mmm_pkg::MMM_SHIFT: begin
          if (mdc_evt.rise) begin
            if (bit_reg == `MMM_BIT_LAST) begin
              state_reg <= mmm_pkg::MMM_END;
            end else begin
              bit_reg <= bit_reg + `MMM_BIT_ONE;
            end
          end else if (mdc_evt.fall) begin
            mdio_o <= frame_reg[`MMM_FRAME_MSB]; // R23
            mdio_oe_o <= ~(rd_reg & (bit_reg >= `MMM_TA2_IDX)); // R23
          end
        end
        mmm_pkg::MMM_END: begin
          // Hold the last bit through its rising edge, release on the fall
          if (mdc_evt.fall) begin
            state_reg <= mmm_pkg::MMM_IDLE;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
            done_reg <= 1'b1; // R10 R11
          end
        end
      endcase
    end
  end

  // Completion flag: a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (ce_i) begin
      if (done_reg) begin
        flag_reg <= 1'b1; // R21
      end else if (wr_take && hit(wb_adr_i, `MMM_EVENT_OFS) && wb_sel_i[`MMM_DONE_LANE]
                   && wb_dat_i[`MMM_DONE_BIT]) begin
        flag_reg <= 1'b0; // R21
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_take && hit(wb_adr_i, `MMM_ENABLE_OFS) && wb_sel_i[`MMM_DONE_LANE]) begin
        enable_reg <= wb_dat_i[`MMM_DONE_BIT];
      end
      irq_o <= flag_reg & enable_reg; // R21
    end
  end

  // Checking aids: frame as launched, and whether software touched it since
  logic [31:0] orig_reg;
  logic touched_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      orig_reg <= 32'h00000000;
      touched_reg <= 1'b0;
    end else if (ce_i) begin
      if (launch) begin
        orig_reg <= frame_reg;
        touched_reg <= 1'b0;
      end else if (wr_take && hit(wb_adr_i, `MMM_FRAME_OFS)) begin
        touched_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_end_fall;
    state_reg == mmm_pkg::MMM_END && mdc_evt.fall;
  endsequence

  sequence s_done_flag;
    done_reg ##1 flag_reg;
  endsequence

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  no_stopped_launch_a: assert property (
      state_reg == mmm_pkg::MMM_IDLE && div_field == `MMM_DIV_ZERO |=> state_reg == mmm_pkg::MMM_IDLE) // R17
    else $error("frame started with divider zero");
  pending_launch_a: assert property (launch |=> state_reg == mmm_pkg::MMM_ARM && !pend_reg) // R20
    else $error("pending frame not launched");
  preamble_length_a: assert property (
      state_reg == mmm_pkg::MMM_PRE && mdc_evt.rise && bit_reg != `MMM_BIT_LAST |=> state_reg == mmm_pkg::MMM_PRE)
    // R13
    else $error("preamble shorter than 32 bits");
  preamble_skip_a: assert property (
      state_reg == mmm_pkg::MMM_ARM && mdc_evt.fall && divctl_reg[`MMM_SKIP_BIT]
      |=> state_reg == mmm_pkg::MMM_SHIFT && mdio_o == $past(frame_reg[`MMM_FRAME_MSB])) // R13
    else $error("preamble not skipped");
  read_release_a: assert property (
      state_reg == mmm_pkg::MMM_SHIFT && rd_reg && bit_reg > `MMM_TA2_IDX |-> !mdio_oe_o) // R23
    else $error("data line driven during read data");
  write_restore_a: assert property (done_reg && !rd_reg && !touched_reg |-> frame_reg == orig_reg) // R10
    else $error("frame register not restored after write frame");
  read_header_a: assert property (
      done_reg && rd_reg && !touched_reg |-> frame_reg[`MMM_HDR_HI:`MMM_HDR_LO] == orig_reg[`MMM_HDR_HI:`MMM_HDR_LO])
    // R11
    else $error("header not restored after read frame");
  done_event_a: assert property (s_end_fall |=> s_done_flag) // R10 R11 R21
    else $error("completion flag not raised");
  irq_gate_a: assert property (irq_o |-> $past(flag_reg) && $past(enable_reg)) // R21
    else $error("interrupt without flag and enable");

endmodule

//--- mmm_top_tb.sv
// Self-checking bench: Wishbone register traffic plus a PHY model on the pins.
// Assumes each request is answered one cycle after it is taken.
`timescale 1ns/1ps
`include "mmm_regs.svh"
module mmm_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] fr;
  logic [15:0] rd_val = 16'hbeef;
  logic mdc_o, mdio_o, mdio_oe_o, irq_o, wb_ack_o, line;
  logic [31:0] wb_dat_o, sr;
  logic [6:0] len;
  logic mdc_q = 1'b0;
  int run = 0, hi_len = 0, lo_len = 0, cyc_cnt = 0, error_cnt = 0, cmp_count = 0;

  mmm_top #(.ADDR_W(16)) mmm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mdc_o(mdc_o), .mdio_i(mdio_oe_o ? mdio_o : line), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o), .irq_o(irq_o));
  mmm_phy_model mmm_phy_model_inst (.clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc_o), .dat_i(mdio_o),
    .oe_i(mdio_oe_o), .rdata_i(rd_val), .line_o(line), .sr_o(sr), .len_o(len));

  always #25 clk_i = ~clk_i;

  task automatic tally_and_finish();
    $display("COUNTS compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Half-period monitor and hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    mdc_q <= mdc_o;
    if (mdc_o !== mdc_q) begin
      if (mdc_q)
        hi_len <= run;
      else
        lo_len <= run;
      run <= 1;
    end else
      run <= run + 1;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_done();
    rdat = 32'h0;
    while (rdat[`MMM_DONE_BIT] !== 1'b1)
      bus(1'b0, `MMM_EVENT_OFS, 32'h0, 4'hf);
    // Let the model see the release at the next mdc fall
    repeat (16) @(posedge clk_i);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, `MMM_DIVCTL_OFS, 32'h0, 4'hf);
    chk("divctl_reset", rdat, 32'h0);
    bus(1'b0, `MMM_ENABLE_OFS, 32'h0, 4'hf);
    chk("enable_reset", rdat, 32'h0);
    bus(1'b0, 16'h3100, 32'h0, 4'hf);
    chk("unmapped", rdat, 32'h0);
    bus(1'b1, `MMM_DIVCTL_OFS, 32'h4, 4'he);
    bus(1'b0, `MMM_DIVCTL_OFS, 32'h0, 4'hf);
    chk("divctl_lane", rdat, 32'h0);
    $display("END reset_values");
    fr = {2'b01, 2'b01, 5'h11, 5'h05, 2'b10, 16'ha55a};
    bus(1'b1, `MMM_FRAME_OFS, fr, 4'hf);
    repeat (40) @(posedge clk_i);
    chk("mdc_stopped", 32'(mdc_o), 32'h0);
    chk("oe_stopped", 32'(mdio_oe_o), 32'h0);
    bus(1'b0, `MMM_STATUS_OFS, 32'h0, 4'hf);
    chk("pending", 32'(rdat[`MMM_PEND_BIT]), 32'h1);
    bus(1'b1, `MMM_DIVCTL_OFS, 32'h8, 4'hf);
    wait_done();
    chk("wire_frame", sr, fr);
    chk("wire_len", 32'(len), 32'd64);
    chk("mdc_high", hi_len, 4);
    chk("mdc_low", lo_len, 4);
    bus(1'b0, `MMM_FRAME_OFS, 32'h0, 4'hf);
    chk("frame_back", rdat, fr);
    chk("irq_masked", 32'(irq_o), 32'h0);
    bus(1'b1, `MMM_ENABLE_OFS, 32'h00800000, 4'hf);
    repeat (2) @(posedge clk_i);
    chk("irq_on", 32'(irq_o), 32'h1);
    bus(1'b1, `MMM_EVENT_OFS, 32'h00800000, 4'hf);
    bus(1'b0, `MMM_EVENT_OFS, 32'h0, 4'hf);
    chk("flag_clear", rdat, 32'h0);
    chk("irq_off", 32'(irq_o), 32'h0);
    $display("END pending_write");
    bus(1'b1, `MMM_DIVCTL_OFS, 32'h8a, 4'hf);
    for (int i = 0; i < 4; i++) begin
      fr = {2'b01, 2'(i), 5'(i * 7), 5'(31 - i), 2'b10, 12'h100, 4'(i)};
      rd_val = {12'hbee, 4'(i)};
      bus(1'b1, `MMM_FRAME_OFS, fr, 4'hf);
      wait_done();
      chk("irq_done", 32'(irq_o), 32'h1);
      bus(1'b1, `MMM_EVENT_OFS, 32'h00800000, 4'hf);
      bus(1'b0, `MMM_FRAME_OFS, 32'h0, 4'hf);
      chk("frame_end", rdat, i[1] ? {fr[31:16], rd_val} : fr);
      chk("wire_bits", i[1] ? {17'h0, sr[14:0]} : sr, i[1] ? {17'h0, fr[31:17]} : fr);
      chk("skip_len", 32'(len), i[1] ? 32'd15 : 32'd32);
    end
    chk("mdc_high5", hi_len, 5);
    chk("mdc_low5", lo_len, 5);
    $display("END op_codes");
    bus(1'b1, `MMM_DIVCTL_OFS, 32'h0, 4'hf);
    repeat (20) @(posedge clk_i);
    chk("mdc_parked", 32'(mdc_o), 32'h0);
    $display("END clock_stop");
    tally_and_finish();
  end
endmodule
